// [core/wdtu_pkg.sv]
package wdtu_pkg;
   // Register map (byte addresses inside the slave window)
   localparam logic [15:0] CTRL_OFFSET     = 16'h3990;
   localparam logic [15:0] CTRL_CLR_OFFSET = 16'h3994;
   localparam logic [15:0] CTRL_SET_OFFSET = 16'h3998;
   localparam logic [15:0] CTRL_INV_OFFSET = 16'h399C;
   localparam logic [15:0] IRQ_STAT_OFFSET = 16'h39A0;
   localparam logic [15:0] IRQ_CLR_OFFSET  = 16'h39A4;
   localparam logic [15:0] IRQ_EN_OFFSET   = 16'h39A8;

   // Control register fields
   localparam int         KEY_LSB     = 16;
   localparam int         ON_BIT      = 15;
   localparam int         RUN_POSTSCALE_COPY_LSB  = 8;
   localparam int         RUN_CLOCK_SELECT_COPY_LSB  = 6;
   localparam int         SLEEP_POSTSCALE_COPY_LSB  = 1;
   localparam int         WINEN_BIT   = 0;
   localparam logic [15:0] CLEAR_KEY  = 16'h5743;
   localparam logic [15:0] KEY_RESET  = 16'h0000;
   localparam logic        ON_RESET   = 1'b0;

   // Status/interrupt bits
   localparam int         EV_TIMEOUT  = 0;
   localparam int         EV_WAKE     = 1;
   localparam int         EV_WINFAULT = 2;
   localparam int         EV_BADKEY   = 3;
   localparam int         EV_W        = 4;

   // Timing
   localparam int         CLK_NS          = 25;
   localparam int         RESET_PULSE_NS  = 100;
   localparam int         RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int         CNT_W           = 32;

   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : wdtu_pkg

// [core/wdtu_tick_if.sv]
`timescale 1ns/1ps
interface wdtu_tick_if;
   logic       sleep_mode;
   logic [1:0] run_clk_sel;
   logic       low_power_rc_osc_tick;
   logic       sys_tick;
   logic       ext_tick;
   logic       tick;
   modport src (input sleep_mode, run_clk_sel, low_power_rc_osc_tick, sys_tick, ext_tick, output tick);
   modport dst (output sleep_mode, run_clk_sel, low_power_rc_osc_tick, sys_tick, ext_tick, input tick);
endinterface : wdtu_tick_if

// [core/wdtu_tick_sel.sv]
`timescale 1ns/1ps
module wdtu_tick_sel
(
   // Clock and reset
   input  wire logic   aclk,
   input  wire logic   aresetn,
   // Selection
   wdtu_tick_if.src    t
);
   // One registered pulse per counting-clock edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         t.tick <= 1'b0;
      else if (t.sleep_mode)
         t.tick <= t.low_power_rc_osc_tick;
      else
      begin
         unique case (t.run_clk_sel)
            2'h0:    t.tick <= t.low_power_rc_osc_tick;
            2'h1:    t.tick <= t.sys_tick;
            2'h2:    t.tick <= t.ext_tick;
            default: t.tick <= t.low_power_rc_osc_tick;
         endcase
      end
   end
endmodule : wdtu_tick_sel

// [core/watchdog_timer_unit.sv]
`timescale 1ns/1ps
module watchdog_timer_unit
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [15:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [15:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Configuration word
   input  wire logic        cfg_watchdog_enable,
   input  wire logic [4:0]  cfg_run_postscale,
   input  wire logic [1:0]  cfg_run_clock_select,
   input  wire logic [4:0]  cfg_sleep_postscale,
   input  wire logic        cfg_window_disable,
   // Power state and counting clocks
   input  wire logic        sleep_mode,
   input  wire logic        low_power_rc_osc,
   input  wire logic        sys_count_tick,
   input  wire logic        ext_count_tick,
   // Outputs to the system
   output logic             device_reset,
   output logic             wake_request,
   output logic             irq
);
   // Control state
   logic                  wdt_on;
   logic [4:0]            run_postscale_copy;
   logic [1:0]            run_clock_select_copy;
   logic [4:0]            sleep_postscale_copy;
   logic                  window_mode_enable;
   logic                  cfg_loaded;
   logic [wdtu_pkg::CNT_W-1:0] count;
   logic [$clog2(wdtu_pkg::RESET_PULSE_CYC+1)-1:0] rst_cnt;
   logic [wdtu_pkg::EV_W-1:0] irq_stat;
   logic [wdtu_pkg::EV_W-1:0] irq_en;

   // Bus holding registers
   logic        aw_full;
   logic        w_full;
   logic [15:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   logic        active;
   logic        wr_fire;
   logic        key_hit;
   logic        key_bad;
   logic        limit_hit;
   logic        window_open;
   logic [4:0]  cur_ps;
   logic [31:0] ctrl_rd;
   logic [31:0] next_ctrl;
   logic [wdtu_pkg::EV_W-1:0] ev;

   wdtu_tick_if tif ();
   assign tif.sleep_mode  = sleep_mode;
   assign tif.run_clk_sel = run_clock_select_copy;
   assign tif.low_power_rc_osc_tick   = low_power_rc_osc;
   assign tif.sys_tick    = sys_count_tick;
   assign tif.ext_tick    = ext_count_tick;

   wdtu_tick_sel u_tick
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .t       (tif.src)
   );

   // Period in counting-clock ticks is 2^postscale
   function automatic logic [wdtu_pkg::CNT_W-1:0] period_of(input logic [4:0] ps);
      period_of = wdtu_pkg::CNT_W'(1) << ps;
   endfunction : period_of

   function automatic logic [31:0] ctrl_of(input logic on, input logic [4:0] rd,
                                           input logic [1:0] cs, input logic [4:0] sd,
                                           input logic win);
      ctrl_of = {16'h0000, on, 2'b00, rd, cs, sd, win};
   endfunction : ctrl_of

   assign active  = (cfg_watchdog_enable | wdt_on) & ~device_reset;
   assign cur_ps  = sleep_mode ? sleep_postscale_copy : run_postscale_copy;
   assign limit_hit = active && tif.tick
                      && (count + 1'b1 >= period_of(cur_ps));
   // Window opens for the last quarter of the current period (run or sleep postscale)
   assign window_open = count >= (period_of(cur_ps) - (period_of(cur_ps) >> 2));
   assign ctrl_rd = ctrl_of(wdt_on, run_postscale_copy, run_clock_select_copy,
                            sleep_postscale_copy, window_mode_enable);

   assign wr_fire = aw_full && w_full && !s_axi_bvalid;
   // Only a halfword store to the upper lanes of the base address counts
   assign key_hit = wr_fire && aw_addr == wdtu_pkg::CTRL_OFFSET && w_strb == 4'hC
                    && w_data[31:16] == wdtu_pkg::CLEAR_KEY;
   assign key_bad = wr_fire && aw_addr == wdtu_pkg::CTRL_OFFSET && |w_strb[3:2]
                    && !key_hit;

   // Write channel acceptance: either order, held until the response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full <= 1'b0;
         w_full  <= 1'b0;
         aw_addr <= 16'h0000;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full <= 1'b1;
            aw_addr <= {s_axi_awaddr[15:2], 2'b00};
         end
         else if (wr_fire)
            aw_full <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_full <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_full && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= wdtu_pkg::AXI_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         unique case (aw_addr)
            wdtu_pkg::CTRL_OFFSET, wdtu_pkg::CTRL_CLR_OFFSET, wdtu_pkg::CTRL_SET_OFFSET,
            wdtu_pkg::CTRL_INV_OFFSET, wdtu_pkg::IRQ_STAT_OFFSET,
            wdtu_pkg::IRQ_CLR_OFFSET, wdtu_pkg::IRQ_EN_OFFSET:
               s_axi_bresp <= wdtu_pkg::AXI_OKAY;
            default:
               s_axi_bresp <= wdtu_pkg::AXI_SLVERR;
         endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Writable control bits after alias arithmetic
   always_comb
   begin
      next_ctrl = ctrl_rd;
      unique case (aw_addr)
         wdtu_pkg::CTRL_OFFSET:
         begin
            if (w_strb[1])
               next_ctrl[15:8] = w_data[15:8];
            if (w_strb[0])
               next_ctrl[7:0] = w_data[7:0];
         end
         wdtu_pkg::CTRL_CLR_OFFSET: next_ctrl = ctrl_rd & ~w_data;
         wdtu_pkg::CTRL_SET_OFFSET: next_ctrl = ctrl_rd | w_data;
         wdtu_pkg::CTRL_INV_OFFSET: next_ctrl = ctrl_rd ^ w_data;
         default:                   next_ctrl = ctrl_rd;
      endcase
   end

   // Shadow copies load from the configuration word on every reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cfg_loaded <= 1'b0;
      else
         cfg_loaded <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         run_postscale_copy    <= 5'h00;
         run_clock_select_copy <= 2'h0;
         sleep_postscale_copy  <= 5'h00;
      end
      else if (!cfg_loaded)
      begin
         run_postscale_copy    <= cfg_run_postscale;
         run_clock_select_copy <= cfg_run_clock_select;
         sleep_postscale_copy  <= cfg_sleep_postscale;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wdt_on             <= wdtu_pkg::ON_RESET;
         window_mode_enable <= 1'b0;
      end
      else if (!cfg_loaded)
         window_mode_enable <= ~cfg_window_disable;
      else if (wr_fire)
      begin
         wdt_on             <= next_ctrl[wdtu_pkg::ON_BIT];
         window_mode_enable <= next_ctrl[wdtu_pkg::WINEN_BIT];
      end
   end

   // Counter; key writes outside the window fault in windowed mode
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !active)
         count <= '0;
      else if (key_hit)
         count <= '0;
      else if (limit_hit)
         count <= '0;
      else if (tif.tick)
         count <= count + 1'b1;
   end

   always_comb
   begin
      ev = '0;
      ev[wdtu_pkg::EV_TIMEOUT]  = limit_hit && !sleep_mode;
      ev[wdtu_pkg::EV_WAKE]     = limit_hit && sleep_mode;
      ev[wdtu_pkg::EV_WINFAULT] = active && key_hit && window_mode_enable && !window_open;
      ev[wdtu_pkg::EV_BADKEY]   = key_bad;
   end

   // Reset pulse is stretched so slow reset logic sees it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         device_reset <= 1'b0;
         rst_cnt      <= '0;
      end
      else if (ev[wdtu_pkg::EV_TIMEOUT] || ev[wdtu_pkg::EV_WINFAULT])
      begin
         device_reset <= 1'b1;
         rst_cnt      <= ($bits(rst_cnt))'(wdtu_pkg::RESET_PULSE_CYC - 1);
      end
      else if (rst_cnt != '0)
         rst_cnt <= rst_cnt - 1'b1;
      else
         device_reset <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wake_request <= 1'b0;
      else
         wake_request <= ev[wdtu_pkg::EV_WAKE];
   end

   // Interrupt status: set wins over a simultaneous clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat <= '0;
         irq_en   <= '0;
      end
      else
      begin
         if (wr_fire && aw_addr == wdtu_pkg::IRQ_CLR_OFFSET)
            irq_stat <= (irq_stat & ~w_data[wdtu_pkg::EV_W-1:0]) | ev;
         else
            irq_stat <= irq_stat | ev;
         if (wr_fire && aw_addr == wdtu_pkg::IRQ_EN_OFFSET)
            irq_en <= w_data[wdtu_pkg::EV_W-1:0];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(irq_stat & irq_en);
   end

   // Read channel; key field always reads zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= wdtu_pkg::AXI_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= wdtu_pkg::AXI_OKAY;
            unique case ({s_axi_araddr[15:2], 2'b00})
               wdtu_pkg::CTRL_OFFSET:     s_axi_rdata <= ctrl_rd;
               wdtu_pkg::CTRL_CLR_OFFSET, wdtu_pkg::CTRL_SET_OFFSET,
               wdtu_pkg::CTRL_INV_OFFSET,
               wdtu_pkg::IRQ_CLR_OFFSET:  s_axi_rdata <= 32'h0000_0000;
               wdtu_pkg::IRQ_STAT_OFFSET: s_axi_rdata <= {28'h0000000, irq_stat};
               wdtu_pkg::IRQ_EN_OFFSET:   s_axi_rdata <= {28'h0000000, irq_en};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= wdtu_pkg::AXI_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   property p_timeout_reset;
      @(posedge aclk) disable iff (!aresetn) ev[wdtu_pkg::EV_TIMEOUT] |=> device_reset;
   endproperty
   a_timeout_reset: assert property (p_timeout_reset) else $error("no reset on timeout");

   property p_wake_not_reset;
      @(posedge aclk) disable iff (!aresetn)
         (limit_hit && sleep_mode) |=> wake_request && !$rose(device_reset);
   endproperty
   a_wake_not_reset: assert property (p_wake_not_reset) else $error("sleep timeout wrong");

   property p_key_clears;
      @(posedge aclk) disable iff (!aresetn) (key_hit && active) |=> count == '0;
   endproperty
   a_key_clears: assert property (p_key_clears) else $error("key did not clear");

   property p_badkey_keeps;
      @(posedge aclk) disable iff (!aresetn)
         (key_bad && active && !tif.tick) |=> count == $past(count);
   endproperty
   a_badkey_keeps: assert property (p_badkey_keeps) else $error("bad key changed count");

   property p_fuse_gate;
      @(posedge aclk) disable iff (!aresetn)
         (!cfg_watchdog_enable && !wdt_on) |=> count == '0;
   endproperty
   a_fuse_gate: assert property (p_fuse_gate) else $error("counting while disabled");

   property p_win_fault;
      @(posedge aclk) disable iff (!aresetn) ev[wdtu_pkg::EV_WINFAULT] |=> device_reset;
   endproperty
   a_win_fault: assert property (p_win_fault) else $error("early key not faulted");

   property p_shadow_stable;
      @(posedge aclk) disable iff (!aresetn)
         cfg_loaded |=> run_postscale_copy == $past(run_postscale_copy);
   endproperty
   a_shadow_stable: assert property (p_shadow_stable) else $error("shadow changed");

   property p_period_bound;
      @(posedge aclk) disable iff (!aresetn) active |-> count < period_of(cur_ps);
   endproperty
   a_period_bound: assert property (p_period_bound) else $error("count beyond period");
endmodule : watchdog_timer_unit

// [tb/test_watchdog_timer_unit.sv]
`timescale 1ns/1ps
module test_watchdog_timer_unit;
   localparam logic [15:0] a_ctl = wdtu_pkg::CTRL_OFFSET;
   localparam logic [15:0] a_st  = wdtu_pkg::IRQ_STAT_OFFSET;
   localparam logic [15:0] a_ic  = wdtu_pkg::IRQ_CLR_OFFSET;
   localparam logic [15:0] a_ie  = wdtu_pkg::IRQ_EN_OFFSET;
   localparam logic [1:0]  ok    = wdtu_pkg::AXI_OKAY;
   localparam logic [31:0] s_to  = 32'h1 << wdtu_pkg::EV_TIMEOUT;
   localparam logic [31:0] s_wk  = 32'h1 << wdtu_pkg::EV_WAKE;
   localparam logic [31:0] s_wf  = 32'h1 << wdtu_pkg::EV_WINFAULT;
   localparam logic [31:0] s_bk  = 32'h1 << wdtu_pkg::EV_BADKEY;
   logic        aclk = 1'b0, aresetn = 1'b0, dprev = 1'b0;
   logic [15:0] awa = 16'h0, ara = 16'h0;
   logic [31:0] wd = 32'h0, rd, ctrl, r;
   logic [3:0]  ws = 4'h0;
   logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic        awr, wr, bv, arr, rv, drst, wake, irq;
   logic [1:0]  br, rr;
   logic        fen = 1'b0, wdis = 1'b1, slp = 1'b0, lp = 1'b0, st = 1'b0, et = 1'b0;
   logic [4:0]  rps = 5'h03, sps = 5'h02;
   logic [1:0]  rcs = 2'h1;
   int          bad_count = 0, check_count = 0, cyc = 0, rst_n = 0, wake_n = 0, n0, w0;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];

   always #12.5 aclk = ~aclk;

   watchdog_timer_unit dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .cfg_watchdog_enable(fen), .cfg_run_postscale(rps), .cfg_run_clock_select(rcs),
      .cfg_sleep_postscale(sps), .cfg_window_disable(wdis), .sleep_mode(slp),
      .low_power_rc_osc(lp), .sys_count_tick(st), .ext_count_tick(et),
      .device_reset(drst), .wake_request(wake), .irq(irq));

   task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   // Monitor: pops the oldest note whenever an answer is handed over
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      dprev <= drst;
      if (drst === 1'b1 && dprev !== 1'b1)
         rst_n <= rst_n + 1;
      if (wake === 1'b1)
         wake_n <= wake_n + 1;
      if (rv === 1'b1 && rre)
         chk("rdata", rq.pop_front(), {rr, rd});
      if (bv === 1'b1 && bre)
         chk("bresp", {32'h0, bq.pop_front()}, {32'h0, br});
      if (cyc > 20000)
      begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic wr_reg(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                         input logic [1:0] e);
      bit ad = 0, dd = 0;
      @(posedge aclk);
      bq.push_back(e);
      awa <= a;
      wd  <= d;
      ws  <= s;
      awv <= 1'b1;
      wv  <= 1'b1;
      while (!(ad && dd))
      begin
         @(posedge aclk);
         if (awv && awr === 1'b1)
         begin
            awv <= 1'b0;
            ad = 1;
         end
         if (wv && wr === 1'b1)
         begin
            wv <= 1'b0;
            dd = 1;
         end
      end
      bre <= 1'b1;
      do @(posedge aclk); while (bv !== 1'b1);
      bre <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge aclk);
      rq.push_back({e, d});
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do @(posedge aclk); while (arr !== 1'b1);
      arv <= 1'b0;
      while (rv !== 1'b1) @(posedge aclk);
      rre <= 1'b0;
   endtask : rd_reg

   task key;
      wr_reg(a_ctl, 32'h5743_0000, 4'hC, ok);
   endtask : key

   task automatic tick(input int n, input bit low);
      repeat (n)
      begin
         @(posedge aclk);
         if (low)
            lp <= 1'b1;
         else
            st <= 1'b1;
         @(posedge aclk);
         lp <= 1'b0;
         st <= 1'b0;
         repeat (2) @(posedge aclk);
      end
      repeat (6) @(posedge aclk);
   endtask : tick

   task automatic rst_chk(input int e);
      chk("resets", e, rst_n);
   endtask : rst_chk

   initial
   begin
      r = $urandom(32'h51ccc784);
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      ctrl = {16'h0, 3'h0, 5'h03, 2'h1, 5'h02, ~wdis};
      rd_reg(a_ctl, ctrl, ok);
      $display("test reset values done");
      // Random low-lane data also hits the read-only copies, which must hold
      for (int i = 0; i < 4; i++)
      begin
         r = $urandom & 32'hFFFF;
         wr_reg(a_ctl + 16'(4 * i), r, 4'h3, ok);
         case (i)
            0: ctrl = (ctrl & ~32'h8001) | (r & 32'h8001);
            1: ctrl = ctrl & ~(r & 32'h8001);
            2: ctrl = ctrl | (r & 32'h8001);
            default: ctrl = ctrl ^ (r & 32'h8001);
         endcase
         rd_reg(a_ctl, ctrl, ok);
      end
      wr_reg(a_ctl, 32'h0000_8000, 4'h3, ok);
      ctrl = (ctrl & ~32'h8001) | 32'h8000;
      wr_reg(16'h3000, 32'hFFFF_FFFF, 4'hF, wdtu_pkg::AXI_SLVERR);
      rd_reg(16'h3000, 32'h0, wdtu_pkg::AXI_SLVERR);
      $display("test register access done");
      wr_reg(a_ic, 32'hF, 4'hF, ok);
      wr_reg(a_ie, 32'hF, 4'hF, ok);
      n0 = rst_n;
      key();
      tick(6, 0);
      key();
      tick(6, 0);
      rst_chk(n0);
      rd_reg(a_st, 32'h0, ok);
      tick(4, 0);
      rst_chk(n0 + 1);
      rd_reg(a_st, s_to, ok);
      chk("irq", 34'h1, {33'h0, irq});
      wr_reg(a_ie, 32'h0, 4'hF, ok);
      repeat (2) @(posedge aclk);
      chk("irq masked", 34'h0, {33'h0, irq});
      wr_reg(a_ie, 32'hF, 4'hF, ok);
      wr_reg(a_ic, 32'hF, 4'hF, ok);
      repeat (2) @(posedge aclk);
      chk("irq cleared", 34'h0, {33'h0, irq});
      $display("test time-out done");
      key();
      tick(6, 0);
      wr_reg(a_ctl, 32'h1234_0000, 4'hC, ok);
      wr_reg(a_ctl, 32'h5743_8000, 4'hF, ok);
      tick(3, 0);
      rst_chk(n0 + 2);
      rd_reg(a_st, s_to | s_bk, ok);
      $display("test bad key done");
      wr_reg(a_ic, 32'hF, 4'hF, ok);
      key();
      wr_reg(a_ctl + 16'h8, 32'h1, 4'h1, ok);
      tick(7, 0);
      key();
      rst_chk(n0 + 2);
      key();
      repeat (6) @(posedge aclk);
      rst_chk(n0 + 3);
      rd_reg(a_st, s_wf, ok);
      wr_reg(a_ctl + 16'h4, 32'h1, 4'h1, ok);
      $display("test window done");
      wr_reg(a_ic, 32'hF, 4'hF, ok);
      key();
      w0 = wake_n;
      slp <= 1'b1;
      tick(10, 0);
      chk("wake", w0, wake_n);
      tick(5, 1);
      chk("wake", w0 + 1, wake_n);
      rst_chk(n0 + 3);
      rd_reg(a_st, s_wk, ok);
      slp <= 1'b0;
      $display("test sleep done");
      n0 = rst_n;
      wr_reg(a_ctl + 16'h4, 32'h8000, 4'h3, ok);
      ctrl = ctrl & ~32'h8001;
      key();
      tick(12, 0);
      rst_chk(n0);
      fen <= 1'b1;
      tick(12, 0);
      rst_chk(n0 + 1);
      fen <= 1'b0;
      rd_reg(a_ctl, ctrl, ok);
      $display("test fuse done");
      // A second reset must reload every shadow from the new configuration
      aresetn <= 1'b0;
      rps     <= 5'($urandom);
      rcs     <= 2'($urandom);
      sps     <= 5'($urandom);
      wdis    <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      ctrl = {16'h0, 3'h0, rps, rcs, sps, ~wdis};
      rd_reg(a_ctl, ctrl, ok);
      $display("test second reset done");
      end_of_test();
   end
endmodule : test_watchdog_timer_unit
